// File: shared/mesc_map.svh
// constants of the motion and engine settings command handler
// assumes: included by the package and the design files by bare name
`ifndef MESC_MAP_SVH
`define MESC_MAP_SVH

// ---------------------------------------------------------------------
// command codes and frame lengths
// ---------------------------------------------------------------------
`define MESC_CMD_SET_MOVE 32'h766F6D73
`define MESC_CMD_GET_MOVE 32'h766F6D67
`define MESC_CMD_SET_ENG  32'h676E6573
`define MESC_CMD_GET_ENG  32'h676E6567
`define MESC_MOVE_LEN     6'h1E
`define MESC_ENG_LEN      6'h22
`define MESC_ECHO_LEN     6'h04
`define MESC_CMD_LAST     6'h03
`define MESC_MAX_LEN      34

// ---------------------------------------------------------------------
// byte offsets inside the motion frame
// ---------------------------------------------------------------------
`define MESC_MV_SPEED     4
`define MESC_MV_SPEED_FR  8
`define MESC_MV_ACCEL     9
`define MESC_MV_DECEL     11
`define MESC_MV_BL_SPEED  13
`define MESC_MV_BL_FR     17

// ---------------------------------------------------------------------
// byte offsets inside the engine frame
// ---------------------------------------------------------------------
`define MESC_EN_VOLT      4
`define MESC_EN_CURR      6
`define MESC_EN_SPEED     8
`define MESC_EN_SPEED_FR  12
`define MESC_EN_FLAGS     13
`define MESC_EN_BL_COUNT  15
`define MESC_EN_STEP_DIV  17
`define MESC_EN_STEPS_REV 18

// ---------------------------------------------------------------------
// flag bit positions and step division codes
// ---------------------------------------------------------------------
`define MESC_FL_REVERSE   0
`define MESC_FL_MAX_SPEED 2
`define MESC_FL_BACKLASH  3
`define MESC_FL_ACCEL     4
`define MESC_FL_VOLT      5
`define MESC_FL_CURR      6
`define MESC_FL_SPEED     7
`define MESC_STEP_FULL    8'h01
`define MESC_STEP_FINEST  8'h09

// ---------------------------------------------------------------------
// checksum defaults and reset value of stored bytes
// ---------------------------------------------------------------------
`define MESC_CRC_POLY     16'hA001
`define MESC_CRC_INIT     16'hFFFF
`define MESC_BYTE_RST     8'h00

`endif

// File: shared/mesc_pkg.sv
// types shared by the settings command handler files
// assumes: mesc_map.svh on the include path
`include "mesc_map.svh"

package mesc_pkg;

   // motion profile fields as stored
   typedef struct packed {
      logic [31:0] target_speed;
      logic [7:0]  target_speed_fraction;
      logic [15:0] accel;
      logic [15:0] decel;
      logic [31:0] backlash_approach_speed;
      logic [7:0]  backlash_approach_speed_fraction;
   } mesc_move_t;

   // engine configuration fields as stored
   typedef struct packed {
      logic [15:0]        rated_voltage;
      logic [15:0]        rated_current;
      logic [31:0]        rated_speed;
      logic [7:0]         rated_speed_fraction;
      logic [15:0]        motor_algorithm_flags;
      logic signed [15:0] backlash_count;
      logic [7:0]         step_division_select;
      logic [15:0]        steps_per_rev;
   } mesc_eng_t;

   // controls derived from the engine flags and step division code
   typedef struct packed {
      logic               reverse;
      logic               voltage_cap_en;
      logic               current_cap_en;
      logic               speed_cap_en;
      logic               accel_ramp_en;
      logic               backlash_en;
      logic signed [15:0] backlash_steps;
      logic [31:0]        speed_ceiling;
      logic [7:0]         speed_ceiling_fraction;
      logic               step_mode_valid;
      logic [3:0]         step_shift;
   } mesc_ctrl_t;

   // request parser states
   typedef enum logic [2:0] {
      MESC_IDLE  = 3'b000,
      MESC_CMD   = 3'b001,
      MESC_DATA  = 3'b010,
      MESC_CHECK = 3'b011,
      MESC_REPLY = 3'b100
   } mesc_state_t;

endpackage

// File: rtl/mesc_crc16.sv
// running 16-bit checksum over frame bytes, reflected shift form
// assumes: caller clears at frame start and feeds one byte per cycle
`timescale 1ns/10ps
`default_nettype none
`include "mesc_map.svh"

module mesc_crc16 #(
   parameter logic [15:0] POLY = `MESC_CRC_POLY,
   parameter logic [15:0] INIT = `MESC_CRC_INIT
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        clear,
   input  wire logic        feed,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_r,
   output logic      [15:0] crc_nxt
);

   // value after the present byte; clear restarts from the seed
   always_comb begin
      logic [15:0] c;
      c = (clear ? INIT : crc_r) ^ {8'h00, data};
      for (int b = 0; b < 8; b++) begin
         c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
      end
      crc_nxt = c;
   end

   // running register
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         crc_r <= `MESC_CRC_INIT;
      end else if (feed) begin
         crc_r <= crc_nxt;
      end else if (clear) begin
         crc_r <= INIT;
      end
   end

endmodule // mesc_crc16

`default_nettype wire

// File: rtl/mesc_tx.sv
// answer serialiser: command code, then stored body and trailing checksum when longer than four bytes
// assumes: link side takes a byte when tx_valid and tx_ready are high
`timescale 1ns/10ps
`default_nettype none
`include "mesc_map.svh"

module mesc_tx (
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   input  wire logic                         start,
   input  wire logic [31:0]                  cmd,
   input  wire logic [5:0]                   len,
   input  wire logic [`MESC_MAX_LEN*8-1:0]   frame,
   output logic      [7:0]                   tx_data_r,
   output logic                              tx_valid_r,
   input  wire logic                         tx_ready,
   output logic                              tx_done_r
);

   logic [`MESC_MAX_LEN*8-1:0] frame_r;
   logic [31:0]                cmd_r;
   logic [5:0]                 len_r;
   logic [5:0]                 idx_r;
   logic [5:0]                 nidx;
   logic                       take;
   logic [15:0]                crc_r;
   logic [15:0]                crc_nxt;
   logic [7:0]                 next_byte;

   assign take = tx_valid_r && tx_ready;
   assign nidx = idx_r + 6'h01;

   // checksum over every byte ahead of the checksum itself
   mesc_crc16 u_crc (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clear    (start),
      .feed     (take && (idx_r < len_r - 6'h02) && (len_r > 6'h04)),
      .data     (tx_data_r),
      .crc_r    (crc_r),
      .crc_nxt  (crc_nxt)
   );

   // byte that follows the one now offered, low byte first
   always_comb begin
      if (nidx <= `MESC_CMD_LAST) begin
         next_byte = cmd_r[nidx[1:0]*8 +: 8];
      end else if (nidx == len_r - 6'h02) begin
         next_byte = crc_nxt[7:0];
      end else if (nidx == len_r - 6'h01) begin
         next_byte = crc_r[15:8];
      end else begin
         next_byte = frame_r[nidx*8 +: 8];
      end
   end

   // frame capture and byte stepping
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         frame_r    <= '0;
         cmd_r      <= 32'h0000_0000;
         len_r      <= 6'h00;
         idx_r      <= 6'h00;
         tx_data_r  <= 8'h00;
         tx_valid_r <= 1'b0;
         tx_done_r  <= 1'b0;
      end else begin
         tx_done_r <= 1'b0;
         if (start) begin
            frame_r    <= frame;
            cmd_r      <= cmd;
            len_r      <= len;
            idx_r      <= 6'h00;
            tx_data_r  <= cmd[7:0];
            tx_valid_r <= 1'b1;
         end else if (take) begin
            if (nidx == len_r) begin
               tx_valid_r <= 1'b0;
               tx_done_r  <= 1'b1;
            end else begin
               idx_r     <= nidx;
               tx_data_r <= next_byte;
            end
         end
      end
   end

endmodule // mesc_tx

`default_nettype wire

// File: rtl/mesc_cmd.sv
// motion profile and engine settings command handler
// assumes: byte link on core_clk delivers rx bytes with a first-byte mark;
// motion logic consumes the stored fields and derived controls
`timescale 1ns/10ps
`default_nettype none
`include "mesc_map.svh"

module mesc_cmd
   import mesc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        rx_valid,
   input  wire logic        rx_first,
   input  wire logic [7:0]  rx_data,
   output logic      [7:0]  tx_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   input  wire logic [31:0] max_reachable_speed,
   output mesc_move_t       move_cfg_r,
   output mesc_eng_t        eng_cfg_r,
   output mesc_ctrl_t       ctrl_r,
   output logic             busy_r,
   output logic             crc_error_r
);

   // ------------------------------------------------------------------
   // storage
   // ------------------------------------------------------------------
   logic [7:0]  rx_buf   [0:`MESC_MAX_LEN-1];
   logic [7:0]  move_mem [0:`MESC_MAX_LEN-1];
   logic [7:0]  eng_mem  [0:`MESC_MAX_LEN-1];

   mesc_state_t state_r;
   logic [5:0]  idx_r;
   logic [5:0]  len_r;
   logic [23:0] cmd_lo_r;
   logic [31:0] cmd_full;
   logic        is_eng_r;
   logic        sel_eng_r;
   logic        start_r;
   logic [31:0] reply_cmd_r;
   logic [5:0]  reply_len_r;
   logic        take;
   logic        crc_feed;
   logic        crc_match;
   logic [15:0] rx_crc_r;
   logic [15:0] rx_crc_nxt;
   logic        tx_done;
   logic [`MESC_MAX_LEN*8-1:0] reply_frame;

   // ------------------------------------------------------------------
   // request reception
   // ------------------------------------------------------------------

   // bytes are accepted only while no answer is pending
   assign take = rx_valid && (state_r != MESC_REPLY) &&
                 (state_r != MESC_CHECK) &&
                 (rx_first || state_r != MESC_IDLE);
   assign cmd_full = {rx_data, cmd_lo_r};
   assign crc_feed = take && (rx_first || state_r != MESC_DATA ||
                              idx_r < len_r - 6'h02);
   assign crc_match = (rx_crc_r == {rx_buf[len_r - 6'h01],
                                    rx_buf[len_r - 6'h02]});

   mesc_crc16 u_rx_crc (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clear    (take && rx_first),
      .feed     (crc_feed),
      .data     (rx_data),
      .crc_r    (rx_crc_r),
      .crc_nxt  (rx_crc_nxt)
   );

   // staging buffer, filled in arrival order
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < `MESC_MAX_LEN; i++) begin
            rx_buf[i] <= `MESC_BYTE_RST;
         end
      end else if (take) begin
         rx_buf[rx_first ? 6'h00 : idx_r] <= rx_data;
      end
   end

   // parser state machine
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_r     <= MESC_IDLE;
         idx_r       <= 6'h00;
         len_r       <= 6'h00;
         cmd_lo_r    <= 24'h00_0000;
         is_eng_r    <= 1'b0;
         sel_eng_r   <= 1'b0;
         start_r     <= 1'b0;
         reply_cmd_r <= 32'h0000_0000;
         reply_len_r <= 6'h00;
         crc_error_r <= 1'b0;
      end else begin
         start_r     <= 1'b0;
         crc_error_r <= 1'b0;
         unique case (state_r)
            MESC_IDLE, MESC_CMD, MESC_DATA: begin
               if (take && rx_first) begin
                  cmd_lo_r <= {16'h0000, rx_data};
                  idx_r    <= 6'h01;
                  state_r  <= MESC_CMD;
               end else if (take && state_r == MESC_CMD) begin
                  if (idx_r != `MESC_CMD_LAST) begin
                     cmd_lo_r[idx_r[1:0]*8 +: 8] <= rx_data;
                  end
                  idx_r <= idx_r + 6'h01;
                  if (idx_r == `MESC_CMD_LAST) begin
                     unique case (cmd_full)
                        `MESC_CMD_GET_MOVE: begin
                           sel_eng_r   <= 1'b0;
                           reply_cmd_r <= cmd_full;
                           reply_len_r <= `MESC_MOVE_LEN;
                           start_r     <= 1'b1;
                           state_r     <= MESC_REPLY;
                        end
                        `MESC_CMD_GET_ENG: begin
                           sel_eng_r   <= 1'b1;
                           reply_cmd_r <= cmd_full;
                           reply_len_r <= `MESC_ENG_LEN;
                           start_r     <= 1'b1;
                           state_r     <= MESC_REPLY;
                        end
                        `MESC_CMD_SET_MOVE: begin
                           is_eng_r <= 1'b0;
                           len_r    <= `MESC_MOVE_LEN;
                           state_r  <= MESC_DATA;
                        end
                        `MESC_CMD_SET_ENG: begin
                           is_eng_r <= 1'b1;
                           len_r    <= `MESC_ENG_LEN;
                           state_r  <= MESC_DATA;
                        end
                        default: begin
                           state_r <= MESC_IDLE;
                        end
                     endcase
                  end
               end else if (take && state_r == MESC_DATA) begin
                  idx_r <= idx_r + 6'h01;
                  if (idx_r == len_r - 6'h01) begin
                     state_r <= MESC_CHECK;
                  end
               end
            end
            MESC_CHECK: begin
               if (crc_match) begin
                  reply_cmd_r <= is_eng_r ? `MESC_CMD_SET_ENG
                                          : `MESC_CMD_SET_MOVE;
                  reply_len_r <= `MESC_ECHO_LEN;
                  start_r     <= 1'b1;
                  state_r     <= MESC_REPLY;
               end else begin
                  crc_error_r <= 1'b1;
                  state_r     <= MESC_IDLE;
               end
            end
            MESC_REPLY: begin
               if (tx_done) begin
                  state_r <= MESC_IDLE;
               end
            end
            default: begin
               state_r <= MESC_IDLE;
            end
         endcase
      end
   end

   // busy while a frame is being collected or answered
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (state_r != MESC_IDLE);
      end
   end

   // ------------------------------------------------------------------
   // settings storage, committed only on a good checksum
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < `MESC_MAX_LEN; i++) begin
            move_mem[i] <= `MESC_BYTE_RST;
            eng_mem[i]  <= `MESC_BYTE_RST;
         end
      end else if (state_r == MESC_CHECK && crc_match) begin
         for (int i = 0; i < `MESC_MAX_LEN; i++) begin
            if (is_eng_r) begin
               eng_mem[i] <= rx_buf[i];
            end else begin
               move_mem[i] <= rx_buf[i];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // answer path
   // ------------------------------------------------------------------

   // flatten the selected store for the serialiser
   for (genvar g = 0; g < `MESC_MAX_LEN; g++) begin : g_reply
      assign reply_frame[g*8 +: 8] = sel_eng_r ? eng_mem[g] : move_mem[g];
   end

   mesc_tx u_tx (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .start      (start_r),
      .cmd        (reply_cmd_r),
      .len        (reply_len_r),
      .frame      (reply_frame),
      .tx_data_r  (tx_data),
      .tx_valid_r (tx_valid),
      .tx_ready   (tx_ready),
      .tx_done_r  (tx_done)
   );

   // ------------------------------------------------------------------
   // field views, low byte first and packed without gaps
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         move_cfg_r <= '0;
      end else begin
         move_cfg_r.target_speed <= {move_mem[`MESC_MV_SPEED+3],
            move_mem[`MESC_MV_SPEED+2], move_mem[`MESC_MV_SPEED+1],
            move_mem[`MESC_MV_SPEED]};
         move_cfg_r.target_speed_fraction <=
            move_mem[`MESC_MV_SPEED_FR];
         move_cfg_r.accel <= {move_mem[`MESC_MV_ACCEL+1],
            move_mem[`MESC_MV_ACCEL]};
         move_cfg_r.decel <= {move_mem[`MESC_MV_DECEL+1],
            move_mem[`MESC_MV_DECEL]};
         move_cfg_r.backlash_approach_speed <=
            {move_mem[`MESC_MV_BL_SPEED+3], move_mem[`MESC_MV_BL_SPEED+2],
             move_mem[`MESC_MV_BL_SPEED+1],
             move_mem[`MESC_MV_BL_SPEED]};
         move_cfg_r.backlash_approach_speed_fraction <=
            move_mem[`MESC_MV_BL_FR];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         eng_cfg_r <= '0;
      end else begin
         eng_cfg_r.rated_voltage <= {eng_mem[`MESC_EN_VOLT+1],
            eng_mem[`MESC_EN_VOLT]};
         eng_cfg_r.rated_current <= {eng_mem[`MESC_EN_CURR+1],
            eng_mem[`MESC_EN_CURR]};
         eng_cfg_r.rated_speed <= {eng_mem[`MESC_EN_SPEED+3],
            eng_mem[`MESC_EN_SPEED+2], eng_mem[`MESC_EN_SPEED+1],
            eng_mem[`MESC_EN_SPEED]};
         eng_cfg_r.rated_speed_fraction <= eng_mem[`MESC_EN_SPEED_FR];
         eng_cfg_r.motor_algorithm_flags <= {eng_mem[`MESC_EN_FLAGS+1],
            eng_mem[`MESC_EN_FLAGS]};
         eng_cfg_r.backlash_count <= {eng_mem[`MESC_EN_BL_COUNT+1],
            eng_mem[`MESC_EN_BL_COUNT]};
         eng_cfg_r.step_division_select <=
            eng_mem[`MESC_EN_STEP_DIV];
         eng_cfg_r.steps_per_rev <= {eng_mem[`MESC_EN_STEPS_REV+1],
            eng_mem[`MESC_EN_STEPS_REV]};
      end
   end

   // ------------------------------------------------------------------
   // controls derived from the engine flags and step division code
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_r <= '0;
      end else begin
         ctrl_r.reverse <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_REVERSE];
         ctrl_r.voltage_cap_en <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_VOLT];
         ctrl_r.current_cap_en <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_CURR];
         ctrl_r.speed_cap_en <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_SPEED];
         ctrl_r.accel_ramp_en <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_ACCEL];
         ctrl_r.backlash_en <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_BACKLASH];
         // count passes only while compensation is on
         ctrl_r.backlash_steps <=
            eng_cfg_r.motor_algorithm_flags[`MESC_FL_BACKLASH] ?
            eng_cfg_r.backlash_count : 16'sh0000;
         // reachable maximum overrides the stored rated speed
         if (eng_cfg_r.motor_algorithm_flags[`MESC_FL_MAX_SPEED]) begin
            ctrl_r.speed_ceiling          <= max_reachable_speed;
            ctrl_r.speed_ceiling_fraction <= 8'h00;
         end else begin
            ctrl_r.speed_ceiling          <= eng_cfg_r.rated_speed;
            ctrl_r.speed_ceiling_fraction <=
               eng_cfg_r.rated_speed_fraction;
         end
         // division code to right-shift count, full step is zero
         if (eng_cfg_r.step_division_select >= `MESC_STEP_FULL &&
             eng_cfg_r.step_division_select <= `MESC_STEP_FINEST) begin
            ctrl_r.step_mode_valid <= 1'b1;
            ctrl_r.step_shift <= 4'(eng_cfg_r.step_division_select
                                    - `MESC_STEP_FULL);
         end else begin
            ctrl_r.step_mode_valid <= 1'b0;
            ctrl_r.step_shift      <= 4'h0;
         end
      end
   end

endmodule // mesc_cmd

`default_nettype wire

// File: testbench/mesc_cmd_asserts.sv
// port checks of the settings command handler
// assumes: bound to mesc_cmd from the bench top file
`timescale 1ns/10ps
`default_nettype none
module mesc_cmd_asserts
   import mesc_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic [7:0] tx_data,
   input wire mesc_eng_t  eng_cfg_r,
   input wire mesc_ctrl_t ctrl_r,
   input wire logic       crc_error_r,
   input wire logic [31:0] max_reachable_speed
);
   logic [15:0] fl;
   logic [7:0]  sd;
   assign fl = eng_cfg_r.motor_algorithm_flags;
   assign sd = eng_cfg_r.step_division_select;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence stall_s; tx_valid && !tx_ready; endsequence
   hold_byte_a: assert property (stall_s |=> tx_valid && $stable(tx_data))
      else $error("answer byte lost in stall");
   rev_dir_a: assert property (ctrl_r.reverse == $past(fl[0]))
      else $error("reverse control wrong");
   volt_cap_a: assert property (ctrl_r.voltage_cap_en == $past(fl[5]))
      else $error("voltage cap wrong");
   curr_cap_a: assert property (ctrl_r.current_cap_en == $past(fl[6]))
      else $error("current cap wrong");
   ramp_en_a: assert property (ctrl_r.accel_ramp_en == $past(fl[4]))
      else $error("ramp enable wrong");
   bl_steps_a: assert property ($past(fl[3]) |-> ctrl_r.backlash_en
      && ctrl_r.backlash_steps == $past(eng_cfg_r.backlash_count))
      else $error("backlash control wrong");
   rated_cap_a: assert property (!$past(fl[2]) |->
      ctrl_r.speed_cap_en == $past(fl[7])
      && ctrl_r.speed_ceiling == $past(eng_cfg_r.rated_speed))
      else $error("speed ceiling wrong");
   step_mode_a: assert property ($past(sd) >= 1 && $past(sd) <= 9
      |-> ctrl_r.step_mode_valid && ctrl_r.step_shift == $past(sd) - 1)
      else $error("step shift wrong");
   step_bad_a: assert property ($past(sd) == 0 || $past(sd) > 9 |->
      !ctrl_r.step_mode_valid && ctrl_r.step_shift == 0)
      else $error("invalid step code accepted");
   max_sp_a: assert property ($past(fl[2]) |->
      ctrl_r.speed_ceiling == $past(max_reachable_speed)
      && ctrl_r.speed_ceiling_fraction == 8'h00)
      else $error("reachable ceiling wrong");
   drop_quiet_a: assert property (crc_error_r |=>
      (!crc_error_r && !tx_valid) [*3])
      else $error("dropped frame answered");
endmodule // mesc_cmd_asserts
`default_nettype wire

// File: testbench/mesc_host.sv
// host model: takes answer bytes, may stall
// assumes: bench clears the count before each request
`timescale 1ns/10ps
`default_nettype none
module mesc_host (
   input  wire logic       core_clk,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   input  wire logic       slow,
   input  wire logic       clr,
   output logic            tx_ready,
   output logic [7:0]      rcv [34],
   output logic [5:0]      cnt
);
   initial tx_ready = 1'b0;
   // ready each cycle, or every other when slow
   always @(posedge core_clk) tx_ready <= slow ? ~tx_ready : 1'b1;
   // answer bytes kept in arrival order
   always @(posedge core_clk) begin
      if (clr) cnt <= 6'h00;
      else if (tx_valid && tx_ready) begin
         rcv[cnt] <= tx_data;
         cnt <= cnt + 6'h01;
      end
   end
endmodule // mesc_host
`default_nettype wire

// File: testbench/mesc_cmd_bench.sv
// bench of the settings handler: host requests, answer checks
// assumes: mesc_host on the answer side, checker bound below
`timescale 1ns/10ps
`default_nettype none
`include "mesc_map.svh"
module mesc_cmd_bench;
   import mesc_pkg::*;
   logic core_clk=0, nrst=0, rx_valid=0, rx_first=0, slow=0, clr=0;
   logic [7:0]  rx_data=8'h00, tx_data, fb[34], rcv[34];
   logic [5:0]  cnt;
   logic        tx_valid, tx_ready, busy, crc_err;
   mesc_move_t  mv;
   mesc_eng_t   en;
   mesc_ctrl_t  ct;
   int          n_errors=0, checks=0, cyc=0, n_drop=0;
   localparam logic [31:0] MAXSP = 32'h0001_2345;
   initial forever #20 core_clk = ~core_clk;
   mesc_cmd i_mesc_cmd (.core_clk, .nrst, .rx_valid, .rx_first, .rx_data,
      .tx_data, .tx_valid, .tx_ready, .max_reachable_speed(MAXSP),
      .move_cfg_r(mv), .eng_cfg_r(en), .ctrl_r(ct), .busy_r(busy),
      .crc_error_r(crc_err));
   mesc_host i_mesc_host (.core_clk, .tx_data, .tx_valid, .slow, .clr,
      .tx_ready, .rcv, .cnt);
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [15:0] crc(int n);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 0; i < n; i++) begin
         c ^= {8'h00, fb[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   // code and checksum placed low byte first
   task automatic put(logic [31:0] c, int n);
      {fb[3], fb[2], fb[1], fb[0]} = c;
      if (n > 4) {fb[n-1], fb[n-2]} = crc(n - 2);
   endtask
   // request bytes in, answer count awaited
   task automatic send(int n, int rn);
      clr = 1;
      for (int i = 0; i < n; i++) begin
         if (i == 2) chk("busy", busy, 1);
         rx_valid = 1;
         rx_first = (i == 0);
         rx_data = fb[i];
         @(posedge core_clk);
         #1 clr = 0;
      end
      rx_valid = 0;
      for (int t = 0; t < 200 && cnt != rn; t++) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      #1 chk("answer length", 32'(cnt), rn);
      chk("busy after", busy, 0);
      for (int i = 0; i < rn; i++) chk("answer byte", rcv[i], fb[i]);
   endtask
   // dropped frame pulses counted outside reset
   always @(posedge core_clk) if (nrst && crc_err !== 1'b0) n_drop++;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge core_clk);
      #1 nrst = 1;
      chk("stored reset", {30'h0, |mv, |en}, 0);
      for (int i = 4; i < 34; i++) fb[i] = 8'(i * 37 + 5);
      put(`MESC_CMD_SET_MOVE, 30);
      send(30, 4);
      chk("speed", mv.target_speed, {fb[7], fb[6], fb[5], fb[4]});
      chk("decel", mv.decel, {fb[12], fb[11]});
      chk("approach frac", mv.backlash_approach_speed_fraction, fb[17]);
      slow = 1;
      put(`MESC_CMD_GET_MOVE, 30);
      send(4, 30);
      slow = 0;
      fb[13] = 8'hFD;
      fb[14] = 8'h00;
      fb[17] = 8'h05;
      put(`MESC_CMD_SET_ENG, 34);
      send(34, 4);
      chk("ceiling", ct.speed_ceiling, MAXSP);
      chk("ceiling frac", ct.speed_ceiling_fraction, 0);
      chk("backlash", 32'(ct.backlash_steps), {fb[16], fb[15]});
      chk("shift", ct.step_shift, 4);
      put(`MESC_CMD_GET_ENG, 34);
      send(4, 34);
      fb[4] = ~fb[4];
      put(`MESC_CMD_SET_ENG, 34);
      fb[33] = ~fb[33];
      send(34, 0);
      chk("kept voltage", en.rated_voltage, {fb[5], ~fb[4]});
      chk("drops", n_drop, 1);
      final_report();
   end
endmodule // mesc_cmd_bench
bind mesc_cmd mesc_cmd_asserts i_mesc_cmd_asserts (.core_clk, .nrst,
   .tx_valid, .tx_ready, .tx_data, .eng_cfg_r, .ctrl_r, .crc_error_r,
   .max_reachable_speed);
`default_nettype wire
